/* inc/mac_config_one_regs.svh */
// register address, field positions and reset value of the mac configuration one register
`ifndef MAC_CONFIG_ONE_REGS_SVH
`define MAC_CONFIG_ONE_REGS_SVH

`define MAC_CONFIG_ONE_ADDR    8'hc4
`define MAC_CONFIG_ONE_RESET   8'h00
`define CFG1_SHIFT_COUNT_HI    7
`define CFG1_SHIFT_COUNT_LO    6
`define CFG1_EXPECTED_SIGN     5
`define CFG1_SIGNED_ENABLE     4
`define CFG1_B_SOURCE_SELECT   3
`define CFG1_B_POST_INCREMENT  2
`define CFG1_A_SOURCE_SELECT   1
`define CFG1_A_POST_INCREMENT  0
`define READ_ZERO_VALUE        8'h00

`endif

/* inc/mac_config_one_pkg.sv */
// types shared by the mac configuration one control logic
package mac_config_one_pkg;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_FETCH_A = 3'h1,
    ST_FETCH_B = 3'h3,
    ST_EXEC    = 3'h2,
    ST_POST    = 3'h6
  } seq_state_type;

endpackage

/* logic/mac_config_one_control.sv */
// configuration register one of the multiply-accumulate unit with operand sequencing
// Notes on behaviour
// - dma mode with shift enabled: shift accumulator 1 to 4 bits per count code
// - direction bit 0 shifts accumulator left, 1 shifts it right
// - shift enable shifts the 40-bit accumulator one bit and gates dma multi-bit shift
// - after signed operation, sign differing from expected sign sets sign-change flag
// - signed enable 0 gives unsigned arithmetic, 1 gives two's-complement arithmetic
// - dma mode: b source 0 fetches b over dma, 1 reuses b; ignored otherwise
// - dma mode: a source 0 fetches a over dma, 1 reuses a; ignored otherwise
// - b post-increment enable adds one to b after each operation, any mode
// - a post-increment enable adds one to a after each operation, any mode
`timescale 1ns/10ps
`include "mac_config_one_regs.svh"

module mac_config_one_control #(
  parameter int OP_W  = 16,
  parameter int ACC_W = 40
) (
  // clock and reset
  input  wire logic               mclk_in,
  input  wire logic               rstn_in,
  // special-function register port
  input  wire logic [7:0]         sfr_addr_in,
  input  wire logic               sfr_wr_in,
  input  wire logic               sfr_rd_in,
  input  wire logic [7:0]         sfr_wdata_in,
  output logic      [7:0]         sfr_rdata_out,
  // controls held in other configuration registers
  input  wire logic               dma_mode_in,
  input  wire logic               accumulator_shift_enable_in,
  input  wire logic               accumulator_shift_direction_in,
  input  wire logic               sign_change_flag_clear_in,
  // operand loads by the cpu and operation start
  input  wire logic               a_write_in,
  input  wire logic               b_write_in,
  input  wire logic [OP_W-1:0]    operand_data_in,
  input  wire logic               op_start_in,
  // dma operand fetch
  output logic                    dma_a_request_out,
  output logic                    dma_b_request_out,
  input  wire logic               dma_valid_in,
  input  wire logic [OP_W-1:0]    dma_data_in,
  // results and status
  output logic [OP_W-1:0]         a_out,
  output logic [OP_W-1:0]         b_out,
  output logic [ACC_W-1:0]        accumulator_out,
  output logic                    busy_out,
  output logic                    op_done_out,
  output logic                    sign_change_flag_out
);

  typedef struct packed {
    logic [7:0]                        cfg;
    logic [7:0]                        rdata;
    logic [OP_W-1:0]                   a;
    logic [OP_W-1:0]                   b;
    logic [ACC_W-1:0]                  acc;
    mac_config_one_pkg::seq_state_type st;
    logic                              req_a;
    logic                              req_b;
    logic                              busy;
    logic                              done;
    logic                              flag;
  } state_type;

  state_type r;
  state_type next_r;

  logic                    cfg_hit;
  logic [1:0]              shift_count;
  logic                    signed_en;
  logic                    fetch_a;
  logic                    fetch_b;
  logic [2:0]              shift_amount;
  logic signed [2*OP_W-1:0] prod_signed;
  logic [2*OP_W-1:0]       prod_unsigned;
  logic [ACC_W-1:0]        prod_ext;
  logic [ACC_W-1:0]        acc_shifted;

  assign cfg_hit     = (sfr_addr_in == `MAC_CONFIG_ONE_ADDR);
  assign shift_count = r.cfg[`CFG1_SHIFT_COUNT_HI:`CFG1_SHIFT_COUNT_LO];
  assign signed_en   = r.cfg[`CFG1_SIGNED_ENABLE];
  assign fetch_a     = dma_mode_in && !r.cfg[`CFG1_A_SOURCE_SELECT];
  assign fetch_b     = dma_mode_in && !r.cfg[`CFG1_B_SOURCE_SELECT];

  // product in the selected arithmetic, extended to accumulator width
  assign prod_signed   = $signed(r.a) * $signed(r.b);
  assign prod_unsigned = r.a * r.b;
  always_comb begin
    if (signed_en) begin
      prod_ext = {{(ACC_W-2*OP_W){prod_signed[2*OP_W-1]}}, prod_signed};
    end else begin
      prod_ext = {{(ACC_W-2*OP_W){1'b0}}, prod_unsigned};
    end
  end

  // one bit outside dma mode, count plus one inside it
  always_comb begin
    if (!accumulator_shift_enable_in) begin
      shift_amount = 3'h0;
    end else if (dma_mode_in) begin
      shift_amount = {1'b0, shift_count} + 3'h1;
    end else begin
      shift_amount = 3'h1;
    end
  end

  always_comb begin
    if (!accumulator_shift_direction_in) begin
      acc_shifted = r.acc << shift_amount;
    end else if (signed_en) begin
      acc_shifted = ACC_W'($signed(r.acc) >>> shift_amount);
    end else begin
      acc_shifted = r.acc >> shift_amount;
    end
  end

  always_comb begin
    next_r      = r;
    next_r.done = 1'b0;
    if (sfr_wr_in && cfg_hit) begin
      next_r.cfg = sfr_wdata_in;
    end
    if (sfr_rd_in) begin
      if (cfg_hit) begin
        next_r.rdata = r.cfg;
      end else begin
        next_r.rdata = `READ_ZERO_VALUE;
      end
    end
    if (sign_change_flag_clear_in) begin
      next_r.flag = 1'b0;
    end
    case (r.st)
      mac_config_one_pkg::ST_IDLE: begin
        if (a_write_in) begin
          next_r.a = operand_data_in;
        end
        if (b_write_in) begin
          next_r.b = operand_data_in;
        end
        if (op_start_in) begin
          next_r.busy = 1'b1;
          if (fetch_a) begin
            next_r.st    = mac_config_one_pkg::ST_FETCH_A;
            next_r.req_a = 1'b1;
          end else if (fetch_b) begin
            next_r.st    = mac_config_one_pkg::ST_FETCH_B;
            next_r.req_b = 1'b1;
          end else begin
            next_r.st = mac_config_one_pkg::ST_EXEC;
          end
        end
      end
      mac_config_one_pkg::ST_FETCH_A: begin
        if (dma_valid_in) begin
          next_r.a     = dma_data_in;
          next_r.req_a = 1'b0;
          if (fetch_b) begin
            next_r.st    = mac_config_one_pkg::ST_FETCH_B;
            next_r.req_b = 1'b1;
          end else begin
            next_r.st = mac_config_one_pkg::ST_EXEC;
          end
        end
      end
      mac_config_one_pkg::ST_FETCH_B: begin
        if (dma_valid_in) begin
          next_r.b     = dma_data_in;
          next_r.req_b = 1'b0;
          next_r.st    = mac_config_one_pkg::ST_EXEC;
        end
      end
      mac_config_one_pkg::ST_EXEC: begin
        next_r.acc = r.acc + prod_ext;
        next_r.st  = mac_config_one_pkg::ST_POST;
      end
      mac_config_one_pkg::ST_POST: begin
        next_r.acc = acc_shifted;
        if (signed_en && (acc_shifted[ACC_W-1] != r.cfg[`CFG1_EXPECTED_SIGN])) begin
          next_r.flag = 1'b1;
        end
        if (r.cfg[`CFG1_A_POST_INCREMENT]) begin
          next_r.a = r.a + OP_W'(1);
        end
        if (r.cfg[`CFG1_B_POST_INCREMENT]) begin
          next_r.b = r.b + OP_W'(1);
        end
        next_r.done = 1'b1;
        next_r.busy = 1'b0;
        next_r.st   = mac_config_one_pkg::ST_IDLE;
      end
      default: begin
        next_r.st = mac_config_one_pkg::ST_IDLE;
      end
    endcase
    if (!rstn_in) begin
      next_r     = '0;
      next_r.cfg = `MAC_CONFIG_ONE_RESET;
      next_r.st  = mac_config_one_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge mclk_in) begin
    r <= next_r;
  end

  assign sfr_rdata_out        = r.rdata;
  assign dma_a_request_out    = r.req_a;
  assign dma_b_request_out    = r.req_b;
  assign a_out                = r.a;
  assign b_out                = r.b;
  assign accumulator_out      = r.acc;
  assign busy_out             = r.busy;
  assign op_done_out          = r.done;
  assign sign_change_flag_out = r.flag;

  // checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_post;
    r.st == mac_config_one_pkg::ST_POST;
  endsequence

  sequence s_start_dma;
    r.st == mac_config_one_pkg::ST_IDLE && op_start_in && dma_mode_in;
  endsequence

  chk_dma_four_shift: assert property (
    s_post and (accumulator_shift_enable_in && dma_mode_in && !accumulator_shift_direction_in
      && shift_count == 2'h3) |=> r.acc == ($past(r.acc) << 4))
    else $error("dma four-bit left shift wrong");
  chk_right_shift: assert property (
    s_post and (accumulator_shift_enable_in && !dma_mode_in && accumulator_shift_direction_in
      && !signed_en) |=> r.acc == ($past(r.acc) >> 1))
    else $error("one-bit right shift wrong");
  chk_single_shift: assert property (
    s_post and (accumulator_shift_enable_in && !dma_mode_in && !accumulator_shift_direction_in)
      |=> r.acc == ($past(r.acc) << 1))
    else $error("one-bit left shift wrong");
  chk_shift_gated: assert property (
    s_post and !accumulator_shift_enable_in |=> r.acc == $past(r.acc))
    else $error("accumulator shifted while disabled");
  chk_sign_flag: assert property (
    s_post and signed_en
      |=> sign_change_flag_out || (r.acc[ACC_W-1] == $past(r.cfg[`CFG1_EXPECTED_SIGN])))
    else $error("sign change not flagged");
  chk_unsigned_sum: assert property (
    r.st == mac_config_one_pkg::ST_EXEC && !signed_en
      |=> r.acc == $past(r.acc) + ACC_W'($past(r.a)) * ACC_W'($past(r.b)))
    else $error("unsigned accumulate wrong");
  chk_fetch_a_req: assert property (
    s_start_dma and fetch_a |=> dma_a_request_out && !dma_b_request_out)
    else $error("a fetch not requested");
  chk_reuse_a: assert property (
    s_start_dma and (!fetch_a && fetch_b) |=> dma_b_request_out && !dma_a_request_out)
    else $error("b fetch not requested when a is reused");
  chk_b_post_inc: assert property (
    s_post and !r.cfg[`CFG1_B_POST_INCREMENT] |=> b_out == $past(r.b))
    else $error("b changed without post increment");
  chk_a_post_inc: assert property (
    s_post and r.cfg[`CFG1_A_POST_INCREMENT] |=> a_out == $past(r.a) + OP_W'(1))
    else $error("a not incremented");
  chk_inc_after_op: assert property (
    r.st == mac_config_one_pkg::ST_EXEC |=> a_out == $past(r.a) ##1 op_done_out)
    else $error("operand moved before accumulator write");

endmodule // mac_config_one_control

/* tb/dma_partner_model.sv */
// dma engine model answering the operand fetch requests
`timescale 1ns/10ps
module dma_partner_model (
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rstn_in,
  // fetch handshake and words to hand back
  input  wire logic        a_req_in,
  input  wire logic        b_req_in,
  input  wire logic [1:0]  wait_in,
  input  wire logic [15:0] a_word_in,
  input  wire logic [15:0] b_word_in,
  output logic             valid_out,
  output logic [15:0]      data_out
);
  logic [1:0] cnt;
  logic       fire;

  // answer after wait_in idle cycles, a before b
  assign fire = rstn_in && !valid_out && (a_req_in || b_req_in) && cnt == wait_in;

  always_ff @(posedge mclk_in) begin
    // data is only meaningful with valid, else it toggles
    data_out <= !rstn_in ? 16'h0000 : fire ? (a_req_in ? a_word_in : b_word_in) : ~data_out;
    if (!rstn_in || valid_out || !(a_req_in || b_req_in)) begin
      cnt <= 2'h0;
      valid_out <= 1'b0;
    end else if (fire) begin
      valid_out <= 1'b1;
    end else begin
      cnt <= cnt + 2'h1;
    end
  end
endmodule // dma_partner_model

/* tb/test_mac_config_one_control.sv */
// self-checking bench of the mac configuration one control block
`timescale 1ns/10ps
`include "mac_config_one_regs.svh"
module test_mac_config_one_control;
  logic        mclk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0, rd = 1'b0, dma = 1'b0, shen = 1'b0, shdir = 1'b0, clr = 1'b0;
  logic        aw = 1'b0, bw = 1'b0, start = 1'b0;
  logic [15:0] opd = 16'h0000, fa = 16'h0000, fb = 16'h0000;
  logic [1:0]  dwait = 2'h0;
  logic [7:0]  rdata;
  logic        areq, breq, dvalid, busy, done, flag;
  logic [15:0] dd, a_q, b_q;
  logic [39:0] acc;
  logic [39:0] e_acc;
  int          error_cnt = 0;
  int          samples_checked = 0;

  always #2 mclk_in = ~mclk_in;

  mac_config_one_control i_mac_config_one_control (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .sfr_addr_in(addr), .sfr_wr_in(wr),
    .sfr_rd_in(rd), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .dma_mode_in(dma),
    .accumulator_shift_enable_in(shen), .accumulator_shift_direction_in(shdir),
    .sign_change_flag_clear_in(clr), .a_write_in(aw), .b_write_in(bw),
    .operand_data_in(opd), .op_start_in(start), .dma_a_request_out(areq),
    .dma_b_request_out(breq), .dma_valid_in(dvalid), .dma_data_in(dd), .a_out(a_q),
    .b_out(b_q), .accumulator_out(acc), .busy_out(busy), .op_done_out(done),
    .sign_change_flag_out(flag));

  dma_partner_model i_dma_partner_model (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .a_req_in(areq), .b_req_in(breq),
    .wait_in(dwait), .a_word_in(fa), .b_word_in(fb), .valid_out(dvalid), .data_out(dd));

  task automatic finish_test;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge mclk_in);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge mclk_in);
    #1;
  endtask

  // accumulate, then optional shift, as the control register asks
  function automatic logic [39:0] mac(input logic [39:0] ac, input logic [15:0] a,
      input logic [15:0] b, input logic [7:0] c, input logic dm, se, sd);
    logic [39:0] x, y;
    int          n;
    x = c[4] ? {{24{a[15]}}, a} : {24'h00_0000, a};
    y = c[4] ? {{24{b[15]}}, b} : {24'h00_0000, b};
    ac = ac + x * y;
    n = dm ? c[7:6] + 1 : 1;
    if (se) ac = sd ? ((c[4] && ac[39]) ? ~(~ac >> n) : ac >> n) : ac << n;
    return ac;
  endfunction

  task automatic do_op(input logic [7:0] c, input logic dm, se, sd);
    logic        sa, sb;
    logic [15:0] ua, ub, xa, xb;
    ua = 16'($urandom);
    ub = 16'($urandom);
    sfr(1'b1, `MAC_CONFIG_ONE_ADDR, c);
    sfr(1'b0, `MAC_CONFIG_ONE_ADDR, 8'h00);
    check(rdata, c);
    @(posedge mclk_in);
    opd <= ua;
    aw <= 1'b1;
    clr <= 1'b1;
    @(posedge mclk_in);
    aw <= 1'b0;
    clr <= 1'b0;
    opd <= ub;
    bw <= 1'b1;
    @(posedge mclk_in);
    bw <= 1'b0;
    dma <= dm;
    shen <= se;
    shdir <= sd;
    fa <= 16'($urandom);
    fb <= 16'($urandom);
    dwait <= 2'($urandom);
    start <= 1'b1;
    @(posedge mclk_in);
    start <= 1'b0;
    sa = 1'b0;
    sb = 1'b0;
    for (int i = 0; i < 40 && done !== 1'b1; i++) begin
      @(posedge mclk_in);
      #1;
      sa |= areq;
      sb |= breq;
      if (done !== 1'b1) begin
        check(busy, 1'b1);
      end
    end
    if (done !== 1'b1) begin
      error_cnt++;
      finish_test();
    end
    xa = (dm && !c[1]) ? fa : ua;
    xb = (dm && !c[3]) ? fb : ub;
    e_acc = mac(e_acc, xa, xb, c, dm, se, sd);
    check(busy, 1'b0);
    check(sa, dm && !c[1]);
    check(sb, dm && !c[3]);
    check(acc, e_acc);
    check(a_q, 16'(xa + c[0]));
    check(b_q, 16'(xb + c[2]));
    check(flag, c[4] && (e_acc[39] != c[5]));
  endtask

  initial begin
    void'($urandom(99));
    e_acc = 40'h00_0000_0000;
    repeat (6) @(posedge mclk_in);
    rstn_in <= 1'b1;
    sfr(1'b0, `MAC_CONFIG_ONE_ADDR, 8'h00);
    check(rdata, `MAC_CONFIG_ONE_RESET);
    // unmapped neighbour: write ignored, read gives zero
    sfr(1'b1, 8'hc5, 8'hff);
    sfr(1'b0, 8'hc5, 8'h00);
    check(rdata, `READ_ZERO_VALUE);
    sfr(1'b0, `MAC_CONFIG_ONE_ADDR, 8'h00);
    check(rdata, `MAC_CONFIG_ONE_RESET);
    // every shift code in dma mode, both directions
    for (int m = 0; m < 8; m++) begin
      do_op({m[1:0], 2'b01, 4'b0101}, 1'b1, 1'b1, m[2]);
    end
    repeat (80) do_op(8'($urandom), 1'($urandom), 1'($urandom), 1'($urandom));
    finish_test();
  end
endmodule // test_mac_config_one_control
